// >>> shared/ddm_pkg.sv
// package: constants, commands and carriers of the ddr mode/command block
package ddm_pkg;
    // data path and model array shape
    localparam int DQ_W      = 16;
    localparam int NBYTE     = 2;
    localparam int ROW_W     = 2;
    localparam int COL_W     = 4;
    localparam int MEM_AW    = 2 + ROW_W + COL_W;
    localparam int MEM_WORDS = 1 << MEM_AW;
    // base mode register field positions and the auto precharge address bit
    localparam int BL_LSB    = 0;
    localparam int ORD_BIT   = 3;
    localparam int CL_LSB    = 4;
    localparam int OM_LSB    = 7;
    localparam int DLLR_BIT  = 8;
    localparam int AP_BIT    = 10;
    // field encodings
    localparam logic [2:0] BL_2       = 3'h1;
    localparam logic [2:0] BL_4       = 3'h2;
    localparam logic [2:0] BL_8       = 3'h3;
    localparam logic [2:0] CL_2       = 3'h2;
    localparam logic [2:0] CL_25      = 3'h6;
    localparam logic [5:0] OM_NORMAL  = 6'h00;
    localparam logic [5:0] OM_DLL_RST = 6'h02;
    // bank select {ba1, ba0} of a load-mode command
    localparam logic [1:0] BA_MODE    = 2'h0;
    localparam logic [1:0] BA_EXT     = 2'h1;
    // reset values
    localparam logic [12:0] MODE_RST  = 13'h0000;
    localparam logic [12:0] EXT_RST   = 13'h0000;
    // timing in link clock cycles
    localparam int         DLL_LOCK_CYC = 200;
    localparam logic [1:0] TRP_CYC      = 2'h3;

    // command code {ras_n, cas_n, we_n} while selected
    typedef enum logic [2:0] {
        CMD_LMR = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR  = 3'h4,
        CMD_RD  = 3'h5,
        CMD_BST = 3'h6,
        CMD_NOP = 3'h7
    } ddm_cmd_t;

    // burst engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RD   = 2'h1,
        ST_WR   = 2'h2
    } ddm_state_t;

    // command pins as registered on the link clock
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] addr;
    } ddm_pins_t;

    // status word handed to the system clock domain
    typedef struct packed {
        logic [2:0]  bl_code;
        logic        burst_order_bit;
        logic [2:0]  cl_code;
        logic [5:0]  opmode;
        logic [12:0] ext;
        logic [3:0]  open;
        logic [7:0]  dll_rst_cnt;
        logic        dll_ready;
    } ddm_status_t;

    // index of the last beat for a burst length code
    function automatic logic [2:0] bl_last(input logic [2:0] code);
        unique case (code)
            BL_4:    bl_last = 3'h3;
            BL_8:    bl_last = 3'h7;
            default: bl_last = 3'h1;
        endcase
    endfunction : bl_last
endpackage : ddm_pkg

// >>> verilog/ddm_burst_col.sv
// module: column address of one beat inside a wrapping burst block
`timescale 1ns/1ps
module ddm_burst_col (
    // burst description
    input  wire logic [9:0] start,
    input  wire logic [2:0] idx,
    input  wire logic [2:0] bl_code,
    input  wire logic       order,
    // column of this beat
    output logic      [9:0] col
);
    logic [2:0] m;
    logic [2:0] seq;
    logic [2:0] itl;
    logic [2:0] low;

    // upper bits pick the block, low bits walk inside it and wrap
    always_comb
    begin
        m   = ddm_pkg::bl_last(bl_code);
        seq = 3'(start[2:0] + idx);
        itl = start[2:0] ^ idx;
        low = order ? itl : seq;
        col = {start[9:3], (start[2:0] & ~m) | (low & m)};
    end
endmodule : ddm_burst_col

// >>> verilog/ddm_top.sv
// module: ddr mode registers, command decode, bank state and burst engine
// Summary of operation
// - burst length 2, 4 or 8, same for reads and writes
// - burst stays in aligned block of burst length and wraps there
// - burst order bit picks sequential or interleaved order
// - offset is (start+i) mod length, or start xor i
// - read latency 2 or 2.5; first data by edge n+m
// - mode load with bits 7..12 zero selects normal mode
// - mode load with only bit 8 set among 7..12 starts dll reset
// - load with bank bits 01 writes extended register, kept till rewritten
// - deselected cycles start nothing; running work goes on
// - selected cycle with ras, cas, we high is a no-operation
// - activate opens row in bank; bank precharged before reopening
// - read/write take bank, column 0..9; bit 10 closes row at end
// - write byte stored only when its mask is low
// - precharge closes selected or all banks; reuse after precharge time
// - precharge of idle or precharging bank does nothing
// - mode fields: length 0..2, order 3, latency 4..6, mode 7..12
// - dll reset bit clears itself; other mode bits are kept
// - precharge bit 10 low: named bank; high: all banks
`timescale 1ns/1ps
module ddm_top (
    // system side
    input  wire logic                     clk,
    input  wire logic                     rst,
    // link clock from the controller
    input  wire logic                     ck,
    // command pins
    input  wire ddm_pkg::ddm_pins_t       pins,
    // data pins
    input  wire logic [ddm_pkg::DQ_W-1:0] dq_in,
    input  wire logic [ddm_pkg::NBYTE-1:0] dm,
    output logic      [ddm_pkg::DQ_W-1:0] dq_out,
    output logic                          dq_oe,
    // status on clk
    output ddm_pkg::ddm_status_t          status
);
    ////////////////////////////////////////////////////////////////////////
    // reset into the link domain
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_ck;

    always_ff @(posedge ck)
    begin
        rst_s1_q <= rst;
        rst_s2_q <= rst_s1_q;
    end
    assign rst_ck = rst_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // command decode
    ddm_pkg::ddm_cmd_t cmd;
    logic [12:0]       adr;
    logic [1:0]        ba;
    logic              sel;
    logic              lmr_base;
    logic              lmr_ext;
    logic              new_burst;
    // bank state and burst owner, read by decode and by both engines
    logic [3:0]        open_q, open_d;
    logic [1:0]        bk_q, bk_d;
    logic              ap_q, ap_d;

    // a deselected cycle decodes to nothing at all
    assign cmd      = ddm_pkg::ddm_cmd_t'({pins.ras_n, pins.cas_n,
                                           pins.we_n});
    assign adr      = pins.addr;
    assign ba       = pins.ba;
    assign sel      = !pins.cs_n;
    assign lmr_base = sel && cmd == ddm_pkg::CMD_LMR
                      && ba == ddm_pkg::BA_MODE;
    assign lmr_ext  = sel && cmd == ddm_pkg::CMD_LMR
                      && ba == ddm_pkg::BA_EXT;
    // reads and writes to a closed bank are dropped
    assign new_burst = sel && (cmd == ddm_pkg::CMD_RD
                      || cmd == ddm_pkg::CMD_WR) && open_q[ba];

    ////////////////////////////////////////////////////////////////////////
    // mode registers, bank state and dll status
    logic [12:0]      mode_q, mode_d;
    logic [12:0]      ext_q, ext_d;
    logic [3:0][1:0]  prc_q, prc_d;
    logic [3:0][ddm_pkg::ROW_W-1:0] row_q, row_d;
    logic             dllr_q, dllr_d;
    logic [7:0]       dllc_q, dllc_d;
    logic [7:0]       lock_q, lock_d;
    logic             rdy_q, rdy_d;
    logic             fin;

    always_comb
    begin
        mode_d = mode_q;
        ext_d  = ext_q;
        open_d = open_q;
        prc_d  = prc_q;
        row_d  = row_q;
        dllr_d = 1'b0;
        dllc_d = dllc_q;
        lock_d = lock_q;
        rdy_d  = rdy_q;
        for (int b = 0; b < 4; b++)
        begin
            if (prc_q[b] != 2'h0)
                prc_d[b] = 2'(prc_q[b] - 2'h1);
        end
        // auto precharge as the burst ends
        if (fin && ap_q)
        begin
            open_d[bk_q] = 1'b0;
            prc_d[bk_q]  = ddm_pkg::TRP_CYC;
        end
        // dll lock count runs after each dll reset
        if (lock_q < 8'(ddm_pkg::DLL_LOCK_CYC))
            lock_d = 8'(lock_q + 8'h01);
        else
            rdy_d = 1'b1;
        if (lmr_base)
        begin
            // the reset bit is never stored
            mode_d = adr & ~(13'h0001 << ddm_pkg::DLLR_BIT);
            if (adr[ddm_pkg::OM_LSB +: 6] == ddm_pkg::OM_DLL_RST)
            begin
                dllr_d = 1'b1;
                dllc_d = 8'(dllc_q + 8'h01);
                lock_d = 8'h00;
                rdy_d  = 1'b0;
            end
        end
        if (lmr_ext)
            ext_d = adr;
        if (sel && cmd == ddm_pkg::CMD_ACT && !open_q[ba]
            && prc_q[ba] == 2'h0)
        begin
            open_d[ba] = 1'b1;
            row_d[ba]  = adr[ddm_pkg::ROW_W-1:0];
        end
        if (sel && cmd == ddm_pkg::CMD_PRE)
        begin
            for (int b = 0; b < 4; b++)
            begin
                // idle or precharging banks are left alone
                if ((adr[ddm_pkg::AP_BIT] || ba == 2'(b)) && open_q[b])
                begin
                    open_d[b] = 1'b0;
                    prc_d[b]  = ddm_pkg::TRP_CYC;
                end
            end
        end
    end

    always_ff @(posedge ck)
    begin
        if (rst_ck)
        begin
            mode_q <= ddm_pkg::MODE_RST;
            ext_q  <= ddm_pkg::EXT_RST;
            open_q <= '0;
            prc_q  <= '0;
            row_q  <= '0;
            dllr_q <= 1'b0;
            dllc_q <= 8'h00;
            lock_q <= 8'h00;
            rdy_q  <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            ext_q  <= ext_d;
            open_q <= open_d;
            prc_q  <= prc_d;
            row_q  <= row_d;
            dllr_q <= dllr_d;
            dllc_q <= dllc_d;
            lock_q <= lock_d;
            rdy_q  <= rdy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst engine and data array
    logic [ddm_pkg::DQ_W-1:0] mem [ddm_pkg::MEM_WORDS];
    ddm_pkg::ddm_state_t      st_q, st_d;
    logic [9:0]               colb_q, colb_d;
    logic [2:0]               idx_q, idx_d;
    logic                     wait_q, wait_d;
    logic [ddm_pkg::DQ_W-1:0] dq_out_q, dq_out_d;
    logic                     dq_oe_q, dq_oe_d;
    logic [2:0]               bl;
    logic [2:0]               last;
    logic [9:0]               col_cur;
    logic [ddm_pkg::MEM_AW-1:0] mem_idx;
    logic                     mem_we;

    assign bl      = mode_q[ddm_pkg::BL_LSB +: 3];
    assign last    = ddm_pkg::bl_last(bl);
    assign mem_idx = {bk_q, row_q[bk_q], col_cur[ddm_pkg::COL_W-1:0]};

    ddm_burst_col u_col (
        .start   (colb_q),
        .idx     (idx_q),
        .bl_code (bl),
        .order   (mode_q[ddm_pkg::ORD_BIT]),
        .col     (col_cur)
    );

    // a new read or write cuts off the burst in flight
    always_comb
    begin
        st_d     = st_q;
        bk_d     = bk_q;
        colb_d   = colb_q;
        idx_d    = idx_q;
        wait_d   = 1'b0;
        ap_d     = ap_q;
        dq_out_d = dq_out_q;
        dq_oe_d  = 1'b0;
        mem_we   = 1'b0;
        fin      = 1'b0;
        unique case (st_q)
            ddm_pkg::ST_IDLE: ;
            ddm_pkg::ST_RD:
            begin
                if (!wait_q)
                begin
                    dq_out_d = mem[mem_idx];
                    dq_oe_d  = 1'b1;
                    idx_d    = 3'(idx_q + 3'h1);
                    fin      = idx_q == last;
                end
            end
            ddm_pkg::ST_WR:
            begin
                mem_we = 1'b1;
                idx_d  = 3'(idx_q + 3'h1);
                fin    = idx_q == last;
            end
            default: ;
        endcase
        if (fin)
            st_d = ddm_pkg::ST_IDLE;
        if (new_burst)
        begin
            st_d   = (cmd == ddm_pkg::CMD_RD) ? ddm_pkg::ST_RD
                                              : ddm_pkg::ST_WR;
            bk_d   = ba;
            colb_d = adr[9:0];
            idx_d  = 3'h0;
            ap_d   = adr[ddm_pkg::AP_BIT];
            // latency 2.5 holds back the first beat by one edge
            wait_d = cmd == ddm_pkg::CMD_RD
                     && mode_q[ddm_pkg::CL_LSB +: 3] == ddm_pkg::CL_25;
        end
    end

    always_ff @(posedge ck)
    begin
        if (rst_ck)
        begin
            st_q     <= ddm_pkg::ST_IDLE;
            bk_q     <= 2'h0;
            colb_q   <= 10'h000;
            idx_q    <= 3'h0;
            wait_q   <= 1'b0;
            ap_q     <= 1'b0;
            dq_out_q <= '0;
            dq_oe_q  <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            bk_q     <= bk_d;
            colb_q   <= colb_d;
            idx_q    <= idx_d;
            wait_q   <= wait_d;
            ap_q     <= ap_d;
            dq_out_q <= dq_out_d;
            dq_oe_q  <= dq_oe_d;
        end
    end

    // byte lanes with mask high keep their old contents
    always_ff @(posedge ck)
    begin
        for (int b = 0; b < ddm_pkg::NBYTE; b++)
        begin
            if (mem_we && !dm[b])
                mem[mem_idx][b*8 +: 8] <= dq_in[b*8 +: 8];
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe  = dq_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // status handshake: link side offers a word, clk side takes it
    ddm_pkg::ddm_status_t live;
    ddm_pkg::ddm_status_t shadow_q, shadow_d;
    logic                 req_q, req_d;
    logic                 ack_s1_q;
    logic                 ack_s2_q;
    logic                 ack_q, ack_d;
    logic                 req_s1_q;
    logic                 req_s2_q;
    ddm_pkg::ddm_status_t status_q, status_d;

    always_comb
    begin
        live.bl_code         = bl;
        live.burst_order_bit = mode_q[ddm_pkg::ORD_BIT];
        live.cl_code         = mode_q[ddm_pkg::CL_LSB +: 3];
        live.opmode          = mode_q[ddm_pkg::OM_LSB +: 6];
        live.ext             = ext_q;
        live.open            = open_q;
        live.dll_rst_cnt     = dllc_q;
        live.dll_ready       = rdy_q;
        shadow_d = shadow_q;
        req_d    = req_q;
        // the shadow only moves once the last offer was taken
        if (req_q == ack_s2_q && live != shadow_q)
        begin
            shadow_d = live;
            req_d    = !req_q;
        end
    end

    always_ff @(posedge ck)
    begin
        ack_s1_q <= ack_q;
        ack_s2_q <= ack_s1_q;
        if (rst_ck)
        begin
            shadow_q <= '0;
            req_q    <= 1'b0;
        end
        else
        begin
            shadow_q <= shadow_d;
            req_q    <= req_d;
        end
    end

    always_comb
    begin
        ack_d    = ack_q;
        status_d = status_q;
        if (req_s2_q != ack_q)
        begin
            status_d = shadow_q;
            ack_d    = req_s2_q;
        end
    end

    always_ff @(posedge clk)
    begin
        req_s1_q <= req_q;
        req_s2_q <= req_s1_q;
        if (rst)
        begin
            ack_q    <= 1'b0;
            status_q <= '0;
        end
        else
        begin
            ack_q    <= ack_d;
            status_q <= status_d;
        end
    end
    assign status = status_q;

    ////////////////////////////////////////////////////////////////////////
    // checks on the link domain
    default clocking cb @(posedge ck); endclocking
    default disable iff (rst_ck);

    a_burst_ends: assert property (
        st_q != ddm_pkg::ST_IDLE && !wait_q && idx_q == last && !new_burst
        |=> st_q == ddm_pkg::ST_IDLE)
        else $error("burst did not end after its last beat");
    a_burst_block: assert property (
        st_q != ddm_pkg::ST_IDLE
        |-> ((col_cur ^ colb_q) & ~{7'h00, last}) == 10'h000)
        else $error("burst left its aligned block");
    a_seq_order: assert property (
        st_q != ddm_pkg::ST_IDLE && !mode_q[ddm_pkg::ORD_BIT]
        |-> col_cur[2:0] == ((3'(colb_q[2:0] + idx_q) & last)
                             | (colb_q[2:0] & ~last)))
        else $error("sequential order wrong");
    a_itl_order: assert property (
        st_q != ddm_pkg::ST_IDLE && mode_q[ddm_pkg::ORD_BIT]
        |-> col_cur[2:0] == (colb_q[2:0] ^ (idx_q & last)))
        else $error("interleaved order wrong");
    a_read_latency: assert property (
        new_burst && cmd == ddm_pkg::CMD_RD
        && mode_q[ddm_pkg::CL_LSB +: 3] == ddm_pkg::CL_25
        |=> (!new_burst |=> !dq_oe_q ##1 dq_oe_q))
        else $error("latency 2.5 first beat misplaced");
    a_dll_pulse: assert property (
        lmr_base && adr[ddm_pkg::OM_LSB +: 6] == ddm_pkg::OM_DLL_RST
        |=> dllr_q && !mode_q[ddm_pkg::DLLR_BIT] ##1 !dllr_q)
        else $error("dll reset not a single self-clearing pulse");
    a_normal_load: assert property (
        lmr_base && adr[ddm_pkg::OM_LSB +: 6] == ddm_pkg::OM_NORMAL
        |=> mode_q == $past(adr) && !dllr_q)
        else $error("normal mode load not stored");
    a_ext_load: assert property (
        lmr_ext |=> ext_q == $past(adr) && $stable(mode_q))
        else $error("extended register load wrong");
    a_deselect: assert property (
        pins.cs_n |=> $stable(mode_q) && $stable(ext_q)
                      && (open_q & ~$past(open_q)) == 4'h0)
        else $error("deselected cycle changed state");
    a_pre_all: assert property (
        sel && cmd == ddm_pkg::CMD_PRE && adr[ddm_pkg::AP_BIT]
        |=> open_q == 4'h0)
        else $error("precharge all left a bank open");
    a_pre_idle: assert property (
        sel && cmd == ddm_pkg::CMD_PRE && !open_q[ba] && !(fin && ap_q)
        && prc_q[ba] != ddm_pkg::TRP_CYC
        |=> prc_q[$past(ba)] != ddm_pkg::TRP_CYC)
        else $error("precharge of idle bank restarted its timer");
endmodule : ddm_top

// >>> verification/ddm_ctrl_model.sv
// file: controller-side model driving command, address and write data
`timescale 1ns/1ps
module ddm_ctrl_model (
    // link clock
    input  wire logic                 ck,
    // pins toward the memory
    output ddm_pkg::ddm_pins_t        pins,
    output logic [ddm_pkg::DQ_W-1:0]  dq_in,
    output logic [ddm_pkg::NBYTE-1:0] dm
);
    logic [36:0] q [$];
    int          n_in;
    int          n_out;

    ////////////////////////////////////////////////////////////////////////
    // start deselected; an empty slot keeps the chip deselected and flips
    // every other line, so nothing stale can pass for a valid value
    initial
    begin
        pins  = '{cs_n: 1'b1, default: '0};
        dq_in = 16'h0000;
        dm    = 2'h0;
        forever
        begin
            @(negedge ck);
            if (q.size() != 0)
            begin
                {pins, dm, dq_in} <= q.pop_front();
                n_out <= n_out + 1;
            end
            else
                {pins, dm, dq_in} <= {1'b1, ~pins[17:0], ~dm, ~dq_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one slot per link cycle; returns once that slot sits on the pins, so
    // callers always queue the next slot away from the driving edge
    task automatic step(input ddm_pkg::ddm_pins_t p, input logic [17:0] d);
        q.push_back({p, d});
        n_in++;
        wait (n_out == n_in);
    endtask : step

    // a selected command; data lines keep toggling
    task automatic cmd(input ddm_pkg::ddm_cmd_t c, input logic [1:0] ba,
                       input logic [12:0] a);
        step({1'b0, c, ba, a}, {~dm, ~dq_in});
    endtask : cmd
endmodule : ddm_ctrl_model

// >>> verification/ddm_top_tb_top.sv
// file: self-checking bench of the ddr mode and command block
`timescale 1ns/1ps
module ddm_top_tb_top;
    // clocks, reset, pins and expectations
    logic                 clk;
    logic                 rst;
    logic                 ck;
    ddm_pkg::ddm_pins_t   pins;
    logic [15:0]          dq_in;
    logic [1:0]           dm;
    logic [15:0]          dq_out;
    logic                 dq_oe;
    ddm_pkg::ddm_status_t status;
    ddm_pkg::ddm_status_t es;
    logic [15:0]          mem [0:7];
    int                   bad_count;
    int                   samples_checked;

    ////////////////////////////////////////////////////////////////////////
    // system clock 25 ns; link clock 6 ns at an unrelated phase
    initial
    begin
        clk = 1'b1;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        ck = 1'b1;
        #1.7;
        forever #3 ck = ~ck;
    end

    ddm_top dut (.clk(clk), .rst(rst), .ck(ck), .pins(pins),
        .dq_in(dq_in), .dm(dm), .dq_out(dq_out), .dq_oe(dq_oe),
        .status(status));
    ddm_ctrl_model u_ctl (.ck(ck), .pins(pins), .dq_in(dq_in), .dm(dm));

    ////////////////////////////////////////////////////////////////////////
    // compare, count, finish
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // status crosses by handshake and may skip values, so poll with a bound
    task automatic st_check;
        int n;
        n = 0;
        while (status !== es && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        check(status, es);
    endtask : st_check

    function automatic int blen(input logic [2:0] c);
        blen = (c == ddm_pkg::BL_8) ? 8 : (c == ddm_pkg::BL_4) ? 4 : 2;
    endfunction : blen

    // column of beat i inside the aligned block, wrapping at its edge
    function automatic logic [2:0] colx(input logic [2:0] s,
                                        input logic [2:0] i);
        logic [2:0] m;
        m = 3'(blen(es.bl_code) - 1);
        colx = es.burst_order_bit ? (s ^ i) : ((s & ~m) | ((s + i) & m));
    endfunction : colx

    // deselected slot whose lines change every cycle
    task automatic idle(input int t);
        u_ctl.step({1'b1, 18'(t)}, {2'h3, 16'(~t)});
    endtask : idle

    // read bank 1 at the next edge, judge dq_oe and data cycle by cycle
    task automatic rd(input logic [2:0] s, input logic ap, input int n,
                      input logic noise);
        int lat;
        lat = (es.cl_code == ddm_pkg::CL_25) ? 2 : 1;
        u_ctl.cmd(ddm_pkg::CMD_RD, 2'h1, {2'h0, ap, 7'h00, s});
        for (int t = 1; t <= lat + n + 4; t++)
        begin
            if (noise && t == 1)
                u_ctl.step({1'b1, ddm_pkg::CMD_RD, 2'h1, 13'h0000},
                           18'h0_0000);
            else if (noise && t == 2)
                u_ctl.cmd(ddm_pkg::CMD_NOP, 2'h1, 13'h0000);
            else
                idle(t);
            if (t > lat && t <= lat + n)
            begin
                check(dq_oe, 1'b1);
                check(dq_out, mem[colx(s, 3'(t - lat - 1))]);
            end
            else
                check(dq_oe, 1'b0);
        end
    endtask : rd

    // burst of 8 into bank 1 from column s; masks on beats 0 and 1
    task automatic wr(input logic [2:0] s, input logic [1:0] m0,
                      input logic [1:0] m1, input logic [7:0] base);
        logic [15:0] d;
        logic [1:0]  m;
        logic [2:0]  c;
        u_ctl.cmd(ddm_pkg::CMD_WR, 2'h1, {10'h000, s});
        for (int i = 0; i < 8; i++)
        begin
            d = {base + 8'(i), ~base - 8'(i)};
            m = (i == 0) ? m0 : (i == 1) ? m1 : 2'h0;
            c = colx(s, 3'(i));
            if (!m[0])
                mem[c][7:0] = d[7:0];
            if (!m[1])
                mem[c][15:8] = d[15:8];
            u_ctl.step({1'b1, 18'(i)}, {m, d});
        end
    endtask : wr

    ////////////////////////////////////////////////////////////////////////
    // bring-up: ext load, dll reset load, lock time on nops, normal load
    task automatic t_init;
        u_ctl.cmd(ddm_pkg::CMD_LMR, ddm_pkg::BA_EXT, 13'h0042);
        u_ctl.cmd(ddm_pkg::CMD_LMR, ddm_pkg::BA_MODE,
                  {ddm_pkg::OM_DLL_RST, ddm_pkg::CL_2, 1'b0,
                   ddm_pkg::BL_8});
        repeat (ddm_pkg::DLL_LOCK_CYC + 2)
            u_ctl.cmd(ddm_pkg::CMD_NOP, 2'h0, 13'h0000);
        u_ctl.cmd(ddm_pkg::CMD_LMR, ddm_pkg::BA_MODE,
                  {ddm_pkg::OM_NORMAL, ddm_pkg::CL_2, 1'b0,
                   ddm_pkg::BL_8});
        es.ext = 13'h0042;
        es.bl_code = ddm_pkg::BL_8;
        es.cl_code = ddm_pkg::CL_2;
        es.dll_rst_cnt = 8'h01;
        es.dll_ready = 1'b1;
        st_check();
        $display("test init done");
    endtask : t_init

    // fill columns 0..7 of a row, read back with bus noise, rewrite under masks, reread
    task automatic t_burst;
        u_ctl.cmd(ddm_pkg::CMD_ACT, 2'h1, 13'h0002);
        es.open = 4'h2;
        st_check();
        wr(3'h0, 2'h0, 2'h0, 8'h10);
        rd(3'h5, 1'b0, 8, 1'b1);
        wr(3'h3, 2'h2, 2'h1, 8'h80);
        rd(3'h3, 1'b0, 8, 1'b0);
        $display("test burst done");
    endtask : t_burst

    // idle-bank precharge is a no-op, single and all-bank precharge, and
    // an activate inside the precharge time is refused
    task automatic t_prech;
        u_ctl.cmd(ddm_pkg::CMD_PRE, 2'h3, 13'h0000);
        u_ctl.cmd(ddm_pkg::CMD_ACT, 2'h0, 13'h0001);
        es.open = 4'h3;
        st_check();
        u_ctl.cmd(ddm_pkg::CMD_PRE, 2'h0, 13'h0000);
        es.open = 4'h2;
        st_check();
        u_ctl.cmd(ddm_pkg::CMD_PRE, 2'h2, 13'h0400);
        u_ctl.cmd(ddm_pkg::CMD_ACT, 2'h1, 13'h0002);
        es.open = 4'h0;
        st_check();
        rd(3'h0, 1'b0, 0, 1'b0);
        $display("test precharge done");
    endtask : t_prech

    // each length, both orders, both latencies; auto precharge then
    // closes the row, so a second read finds the bank shut
    task automatic t_modes;
        logic [9:0] tb [0:4];
        tb[0] = {ddm_pkg::CL_25, 1'b1, ddm_pkg::BL_4, 3'h6};
        tb[1] = {ddm_pkg::CL_2, 1'b0, ddm_pkg::BL_4, 3'h3};
        tb[2] = {ddm_pkg::CL_25, 1'b0, ddm_pkg::BL_2, 3'h1};
        tb[3] = {ddm_pkg::CL_2, 1'b1, ddm_pkg::BL_2, 3'h0};
        tb[4] = {ddm_pkg::CL_25, 1'b1, ddm_pkg::BL_8, 3'h5};
        for (int k = 0; k < 5; k++)
        begin
            es.cl_code = tb[k][9:7];
            es.burst_order_bit = tb[k][6];
            es.bl_code = tb[k][5:3];
            u_ctl.cmd(ddm_pkg::CMD_LMR, ddm_pkg::BA_MODE,
                      {ddm_pkg::OM_NORMAL, tb[k][9:3]});
            st_check();
            u_ctl.cmd(ddm_pkg::CMD_ACT, 2'h1, 13'h0002);
            rd(tb[k][2:0], 1'b1, blen(es.bl_code), 1'b0);
            rd(tb[k][2:0], 1'b0, 0, 1'b0);
        end
        $display("test modes done");
    endtask : t_modes

    ////////////////////////////////////////////////////////////////////////
    // reset, scenarios, verdict
    initial
    begin
        rst = 1'b1;
        es = '0;
        bad_count = 0;
        samples_checked = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++)
            idle(i);
        st_check();
        t_init();
        t_burst();
        t_prech();
        t_modes();
        report_and_stop();
    end

    // the tests take about 4 us; far beyond that means a hang
    initial
    begin
        #200000;
        bad_count++;
        report_and_stop();
    end
endmodule : ddm_top_tb_top
